// >>> logic/itce_pkg.sv
package itce_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned LP_DELAY_NS   = 500;
	localparam int unsigned LP_DELAY_CYC  =
		(LP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  LP_DELAY_LD   = 3'(LP_DELAY_CYC);

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [11:0] OFF_PRG    = 12'h004;
	localparam logic [11:0] OFF_STAT   = 12'h00C;
	localparam logic [11:0] OFF_CFG    = 12'h010;
	localparam logic [11:0] OFF_EVC0   = 12'h020;
	localparam logic [11:0] OFF_EVC1   = 12'h024;
	localparam logic [11:0] OFF_TSC    = 12'h030;
	localparam logic [11:0] OFF_VIC    = 12'h080;
	localparam logic [11:0] OFF_RLD    = 12'h140;
	localparam logic [11:0] OFF_RSA    = 12'h208;
	localparam logic [11:0] OFF_RSB    = 12'h20C;
	localparam logic [11:0] OFF_SSCS   = 12'h2A0;
	localparam logic [11:0] OFF_SSCI   = 12'h2C0;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned STAT_IDLE  = 0;
	localparam int unsigned STAT_OVF   = 2;
	localparam int unsigned STAT_LP    = 3;
	localparam int unsigned CFG_CC     = 4;
	localparam int unsigned EV1_INSTEN = 0;
	localparam int unsigned EV1_BUSTRG = 11;
	localparam int unsigned EV1_LPOVR  = 12;
	localparam int unsigned RS_GRP_LSB = 16;

	////////////////////////////////////////////////////////////////////////
	// Resource groups and instruction batching
	localparam logic [3:0]  GRP_EXT    = 4'h0;
	localparam logic [3:0]  GRP_CMP    = 4'h1;
	localparam logic [3:0]  GRP_CTR    = 4'h2;
	localparam logic [3:0]  GRP_SSC    = 4'h3;
	localparam logic [3:0]  INST_EMIT  = 4'h8;
	localparam logic [3:0]  CNT_MAX    = 4'hF;
	localparam logic [11:0] CC_MAX     = 12'hFFF;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		PK_NONE  = 3'b000,
		PK_INST  = 3'b001,
		PK_EVENT = 3'b010,
		PK_TS    = 3'b011
	} itce_kind_t;

	typedef enum logic [1:0] {
		LP_RUN   = 2'b00,
		LP_DELAY = 2'b01,
		LP_SLEEP = 2'b10
	} itce_lp_t;

	typedef struct packed {
		itce_kind_t  kind;
		logic        trig;
		logic [11:0] cyc;
		logic [3:0]  num;
	} itce_pkt_t;

	typedef struct packed {
		logic [3:0] ext;
		logic [7:0] cmp;
		logic       ctr_zero;
		logic       ssc;
	} itce_res_t;

endpackage

// >>> logic/itce_rsel.sv
`timescale 1ns/1ps
`default_nettype none

module itce_rsel (
	// Selector setting
	input  wire logic              [3:0] group,
	input  wire logic              [7:0] sel,
	// Resources
	input  wire itce_pkg::itce_res_t     res,
	// Result
	output logic                         hit
);

	wire g_ext = group == itce_pkg::GRP_EXT;
	wire g_cmp = group == itce_pkg::GRP_CMP;
	wire g_ctr = group == itce_pkg::GRP_CTR;
	wire g_ssc = group == itce_pkg::GRP_SSC;

	// Selected resources OR together
	wire ext_hit = g_ext & |(sel[3:0] & res.ext);
	wire cmp_hit = g_cmp & |(sel & res.cmp);
	wire ctr_hit = g_ctr & sel[0] & res.ctr_zero;
	wire ssc_hit = g_ssc & sel[0] & res.ssc;

	assign hit = ext_hit | cmp_hit | ctr_hit | ssc_hit;

endmodule

`default_nettype wire

// >>> logic/itce_top.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module itce_top (
	// Clock, reset, enable
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    ce,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic             [11:0] paddr,
	input  wire logic             [31:0] pwdata,
	output logic                         pready,
	output logic                  [31:0] prdata,
	output logic                         pslverr,
	// Processor side
	input  wire logic              [1:0] retire,
	input  wire logic              [7:0] cmp_in,
	input  wire logic                    cpu_sleep,
	// Pins
	input  wire logic              [3:0] ext_in,
	input  wire logic                    niden,
	// Trace bus
	output itce_pkg::itce_pkt_t          trace_pkt,
	output logic                         trace_valid,
	input  wire logic                    trace_ready,
	input  wire logic                    flush_req,
	output logic                         flush_ack
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [3:0] ext_m_q, ext_s_q;
	logic       nid_m_q, nid_s_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_m_q <= 4'h0;
			ext_s_q <= 4'h0;
			nid_m_q <= 1'b0;
			nid_s_q <= 1'b0;
		end
		else if (ce)
		begin
			ext_m_q <= ext_in;
			ext_s_q <= ext_m_q;
			nid_m_q <= niden;
			nid_s_q <= nid_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic        prg_en_q, cfg_cc_q, ovf_q, ssc_q;
	logic [2:0]  evc0_q, tsc_q, vic_q;
	logic [31:0] evc1_q;
	logic [15:0] rld_q, ctr_q;
	logic [19:0] rsa_q, rsb_q;
	logic [7:0]  ssci_q;
	logic [31:0] prdata_q;
	logic        pend_evt_q, pend_ts_q, flush_pend_q, trace_valid_q;
	logic [3:0]  cnt_q;
	logic [11:0] cc_q;
	logic [2:0]  lp_cnt_q;
	itce_pkg::itce_lp_t  lp_q, lp_d;
	itce_pkg::itce_pkt_t pkt_q;

	////////////////////////////////////////////////////////////////////////
	// APB decode
	wire setup  = psel & ~penable & ce;
	wire wr     = psel & penable & pwrite & ce;
	wire wr_prg = wr & (paddr == itce_pkg::OFF_PRG);
	wire wr_cfg = wr & (paddr == itce_pkg::OFF_CFG);
	wire wr_ev0 = wr & (paddr == itce_pkg::OFF_EVC0);
	wire wr_ev1 = wr & (paddr == itce_pkg::OFF_EVC1);
	wire wr_tsc = wr & (paddr == itce_pkg::OFF_TSC);
	wire wr_vic = wr & (paddr == itce_pkg::OFF_VIC);
	wire wr_rld = wr & (paddr == itce_pkg::OFF_RLD);
	wire wr_rsa = wr & (paddr == itce_pkg::OFF_RSA);
	wire wr_rsb = wr & (paddr == itce_pkg::OFF_RSB);
	wire wr_scs = wr & (paddr == itce_pkg::OFF_SSCS);
	wire wr_sci = wr & (paddr == itce_pkg::OFF_SSCI);

	wire lp_ovr     = evc1_q[itce_pkg::EV1_LPOVR];
	wire lp_idle    = lp_q == itce_pkg::LP_SLEEP;
	wire stat_idle  = ~prg_en_q & (cnt_q == 4'h0) & ~trace_valid_q
		& ~pend_evt_q & ~pend_ts_q;
	wire [31:0] stat_val = (32'(stat_idle) << itce_pkg::STAT_IDLE)
		| (32'(ovf_q) << itce_pkg::STAT_OVF)
		| (32'(lp_idle) << itce_pkg::STAT_LP);

	wire [31:0] rd_val =
		(paddr == itce_pkg::OFF_PRG)  ? {31'h0, prg_en_q} :
		(paddr == itce_pkg::OFF_STAT) ? stat_val :
		(paddr == itce_pkg::OFF_CFG)  ?
			(32'(cfg_cc_q) << itce_pkg::CFG_CC) :
		(paddr == itce_pkg::OFF_EVC0) ? {29'h0, evc0_q} :
		(paddr == itce_pkg::OFF_EVC1) ? evc1_q :
		(paddr == itce_pkg::OFF_TSC)  ? {29'h0, tsc_q} :
		(paddr == itce_pkg::OFF_VIC)  ? {29'h0, vic_q} :
		(paddr == itce_pkg::OFF_RLD)  ? {16'h0, rld_q} :
		(paddr == itce_pkg::OFF_RSA)  ? {12'h0, rsa_q} :
		(paddr == itce_pkg::OFF_RSB)  ? {12'h0, rsb_q} :
		(paddr == itce_pkg::OFF_SSCS) ? {31'h0, ssc_q} :
		(paddr == itce_pkg::OFF_SSCI) ? {24'h0, ssci_q} : 32'h0;

	assign pready  = ce;
	assign pslverr = 1'b0;
	assign prdata  = prdata_q;

	wire [31:0] ev1_mask = (32'h1 << itce_pkg::EV1_INSTEN)
		| (32'h1 << itce_pkg::EV1_BUSTRG) | (32'h1 << itce_pkg::EV1_LPOVR);

	////////////////////////////////////////////////////////////////////////
	// Resource selectors
	logic [3:0] rs;
	wire res_act = ~lp_idle;
	itce_pkg::itce_res_t res;
	assign res.ext      = ext_s_q;
	assign res.cmp      = cmp_in;
	assign res.ctr_zero = ctr_q == 16'h0;
	assign res.ssc      = ssc_q;

	assign rs[0] = 1'b0;
	assign rs[1] = 1'b1;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_rs
			logic [19:0] cfg;
			logic        hit;
			assign cfg = (gi == 0) ? rsa_q : rsb_q;
			itce_rsel u_rsel (
				.group (cfg[itce_pkg::RS_GRP_LSB +: 4]),
				.sel   (cfg[7:0]),
				.res   (res),
				.hit   (hit)
			);
			assign rs[gi + 2] = hit & res_act;

			reserved_grp_a: assert property (@(posedge pclk) disable iff (!presetn)
				cfg[itce_pkg::RS_GRP_LSB +: 4] > itce_pkg::GRP_SSC |-> !hit)
				else $error("reserved group produced a hit");
		end
	endgenerate

	// Event select: low bits pick a selector, top bit ORs its pair
	function automatic logic evsel(input logic [2:0] s, input logic [3:0] r);
		evsel = s[2] ? (r[{s[1], 1'b0}] | r[{s[1], 1'b1}]) : r[s[1:0]];
	endfunction

	wire ev0_hit = evsel(evc0_q, rs) & evc1_q[itce_pkg::EV1_INSTEN]
		& prg_en_q;
	wire ts_hit  = evsel(tsc_q, rs) & prg_en_q;
	wire view_ok = evsel(vic_q, rs) & prg_en_q & res_act;

	////////////////////////////////////////////////////////////////////////
	// Low-power sequencing
	always_comb
	begin
		lp_d = lp_q;
		case (lp_q)
			itce_pkg::LP_RUN:
				if (cpu_sleep & ~lp_ovr)
					lp_d = itce_pkg::LP_DELAY;
			itce_pkg::LP_DELAY:
				if (~cpu_sleep | lp_ovr)
					lp_d = itce_pkg::LP_RUN;
				else if (lp_cnt_q == 3'h0)
					lp_d = itce_pkg::LP_SLEEP;
			itce_pkg::LP_SLEEP:
				if (~cpu_sleep | lp_ovr)
					lp_d = itce_pkg::LP_RUN;
			default:
				lp_d = itce_pkg::LP_RUN;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Packet scheduling
	wire slot_free = ~trace_valid_q | trace_ready;
	wire drain     = flush_pend_q | cpu_sleep | ~prg_en_q;
	wire emit_evt  = slot_free & pend_evt_q & res_act;
	wire emit_ts   = slot_free & pend_ts_q & res_act & ~emit_evt;
	wire emit_ins  = slot_free & ~emit_evt & ~emit_ts & (cnt_q != 4'h0)
		& (drain | (cnt_q >= itce_pkg::INST_EMIT));
	wire [1:0] add = view_ok ? 2'({1'b0, retire[1]} + {1'b0, retire[0]})
		: 2'h0;
	wire [4:0] tot = 5'({1'b0, emit_ins ? 4'h0 : cnt_q} + {3'h0, add});
	wire ovf_set   = tot[4] | (ev0_hit & pend_evt_q & ~emit_evt)
		| (ts_hit & pend_ts_q & ~emit_ts);
	wire cc_run    = nid_s_q & res_act & prg_en_q;

	assign flush_ack   = flush_pend_q & (cnt_q == 4'h0) & ~trace_valid_q;
	assign trace_valid = trace_valid_q;
	assign trace_pkt   = pkt_q;

	////////////////////////////////////////////////////////////////////////
	// Registers and state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prg_en_q <= 1'b0;
			cfg_cc_q <= 1'b0;
			evc0_q   <= 3'h0;
			evc1_q   <= 32'h0;
			tsc_q    <= 3'h0;
			vic_q    <= 3'h0;
			rld_q    <= 16'h0;
			rsa_q    <= 20'h0;
			rsb_q    <= 20'h0;
			ssci_q   <= 8'h0;
			prdata_q <= 32'h0;
		end
		else if (ce)
		begin
			if (setup)
				prdata_q <= rd_val;
			if (wr_prg)
				prg_en_q <= pwdata[0];
			if (wr_cfg)
				cfg_cc_q <= pwdata[itce_pkg::CFG_CC];
			if (wr_ev0)
				evc0_q <= pwdata[2:0];
			if (wr_ev1)
				evc1_q <= pwdata & ev1_mask;
			if (wr_tsc)
				tsc_q <= pwdata[2:0];
			if (wr_vic)
				vic_q <= pwdata[2:0];
			if (wr_rld)
				rld_q <= pwdata[15:0];
			if (wr_rsa)
				rsa_q <= pwdata[19:0];
			if (wr_rsb)
				rsb_q <= pwdata[19:0];
			if (wr_sci)
				ssci_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_q        <= 1'b0;
			ssc_q        <= 1'b0;
			ctr_q        <= 16'h0;
			pend_evt_q   <= 1'b0;
			pend_ts_q    <= 1'b0;
			flush_pend_q <= 1'b0;
			cnt_q        <= 4'h0;
			cc_q         <= 12'h0;
			lp_q         <= itce_pkg::LP_RUN;
			lp_cnt_q     <= 3'h0;
		end
		else if (ce)
		begin
			ovf_q <= ovf_set | (ovf_q & ~(wr_prg & pwdata[0]));
			ssc_q <= (res_act & |(cmp_in & ssci_q))
				| (ssc_q & ~(wr_scs & ~pwdata[0]));
			if (wr_rld)
				ctr_q <= pwdata[15:0];
			else if (res_act & cmp_in[0] & (ctr_q != 16'h0))
				ctr_q <= ctr_q - 16'h1;
			pend_evt_q   <= ev0_hit | (pend_evt_q & ~emit_evt);
			pend_ts_q    <= ts_hit | (pend_ts_q & ~emit_ts);
			flush_pend_q <= flush_req | (flush_pend_q & ~flush_ack);
			cnt_q        <= tot[4] ? itce_pkg::CNT_MAX : tot[3:0];
			if (emit_ins)
				cc_q <= 12'h0;
			else if (cc_run & (cc_q != itce_pkg::CC_MAX))
				cc_q <= cc_q + 12'h1;
			lp_q     <= lp_d;
			lp_cnt_q <= (lp_q != itce_pkg::LP_DELAY) ? itce_pkg::LP_DELAY_LD
				: lp_cnt_q - 3'(lp_cnt_q != 3'h0);
		end
	end

	// Output slot, kinds limited to the enum
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trace_valid_q <= 1'b0;
			pkt_q         <= '0;
		end
		else if (ce)
		begin
			if (emit_evt | emit_ts | emit_ins)
			begin
				trace_valid_q <= 1'b1;
				pkt_q.kind    <= emit_evt ? itce_pkg::PK_EVENT :
					emit_ts ? itce_pkg::PK_TS : itce_pkg::PK_INST;
				pkt_q.trig    <= emit_evt & evc1_q[itce_pkg::EV1_BUSTRG];
				pkt_q.cyc     <= (emit_ins & cfg_cc_q) ? cc_q : 12'h0;
				pkt_q.num     <= emit_ins ? cnt_q : 4'h0;
			end
			else if (trace_ready)
				trace_valid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	both_counted_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && view_ok && retire == 2'b11 && !emit_ins && cnt_q <= 4'hD
		|=> cnt_q == $past(cnt_q) + 4'h2)
		else $error("dual retire not counted twice");

	pkt_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
		trace_valid_q |-> pkt_q.kind inside
			{itce_pkg::PK_INST, itce_pkg::PK_EVENT, itce_pkg::PK_TS})
		else $error("illegal packet kind");

	flush_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
		flush_ack |-> cnt_q == 4'h0 && !trace_valid_q && flush_pend_q)
		else $error("flush acked with trace pending");

	lp_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && lp_q == itce_pkg::LP_RUN && cpu_sleep && !lp_ovr
		|=> lp_q == itce_pkg::LP_DELAY)
		else $error("low-power delay skipped");

	lp_override_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && lp_ovr |=> !lp_idle)
		else $error("override did not keep resources active");

	held_event_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && lp_idle && pend_evt_q |=> pend_evt_q)
		else $error("held event lost in low power");

	cc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !cc_run && !emit_ins |=> cc_q == $past(cc_q))
		else $error("cycle counter moved while held");

	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && stat_idle |=> !trace_valid_q)
		else $error("packet emitted while idle");

	ovf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ev0_hit && pend_evt_q && !emit_evt |=> ovf_q)
		else $error("event overrun not flagged");

	fixed_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		rs[0] == 1'b0 && rs[1] == 1'b1)
		else $error("fixed selector pair changed");

endmodule

`default_nettype wire

// >>> verification/itce_sink.sv
`timescale 1ns/1ps
`default_nettype none

module itce_sink (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// Bench control
	input  wire logic                stall,
	input  wire logic                start,
	// Trace bus
	input  wire itce_pkg::itce_pkt_t trace_pkt,
	input  wire logic                trace_valid,
	output logic                     trace_ready,
	output logic                     flush_req,
	input  wire logic                flush_ack
);
	int          n_ev     = 0;
	int          n_pkt    = 0;
	int          inst_sum = 0;
	int          bad_kind = 0;
	logic [11:0] last_cyc = 12'h000;

	////////////////////////////////////////////////////////////////////////
	// Accept unless stalled
	assign trace_ready = !stall;

	////////////////////////////////////////////////////////////////////////
	// Flush request held until acknowledged
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flush_req <= 1'b0;
		else if (start && !flush_req)
			flush_req <= 1'b1;
		else if (flush_req && flush_ack)
			flush_req <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Packet tally
	always @(posedge pclk)
	begin
		if (trace_valid === 1'b1 && trace_ready)
		begin
			n_pkt <= n_pkt + 1;
			case (trace_pkt.kind)
				itce_pkg::PK_EVENT: n_ev <= n_ev + 1;
				itce_pkg::PK_TS:    ;
				itce_pkg::PK_INST:
				begin
					inst_sum <= inst_sum + int'(trace_pkt.num);
					last_cyc <= trace_pkt.cyc;
				end
				default: bad_kind <= bad_kind + 1;
			endcase
		end
	end
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("unexpected %s: expected %0h seen %0h", nm, e, g); \
		end \
	end

module tb_top;
	logic                pclk      = 1'b0;
	logic                presetn   = 1'b0;
	logic                psel      = 1'b0;
	logic                penable   = 1'b0;
	logic                pwrite    = 1'b0;
	logic         [11:0] paddr     = 12'h000;
	logic         [31:0] pwdata    = 32'h0;
	logic          [1:0] retire    = 2'b00;
	logic          [7:0] cmp_in    = 8'h00;
	logic                cpu_sleep = 1'b0;
	logic          [3:0] ext_in    = 4'h0;
	logic                stall     = 1'b0;
	logic                start     = 1'b0;
	logic                pready;
	logic         [31:0] prdata;
	itce_pkg::itce_pkt_t trace_pkt;
	logic                trace_valid;
	logic                trace_ready;
	logic                flush_req;
	logic                flush_ack;
	int                  miscompares = 0;
	int                  n_checks    = 0;

	always #50 pclk = ~pclk;

	itce_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(), .retire(retire),
		.cmp_in(cmp_in), .cpu_sleep(cpu_sleep), .ext_in(ext_in),
		.niden(1'b1), .trace_pkt(trace_pkt), .trace_valid(trace_valid),
		.trace_ready(trace_ready), .flush_req(flush_req),
		.flush_ack(flush_ack));

	itce_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall),
		.start(start), .trace_pkt(trace_pkt), .trace_valid(trace_valid),
		.trace_ready(trace_ready), .flush_req(flush_req),
		.flush_ack(flush_ack));

	////////////////////////////////////////////////////////////////////////
	// Bus and helper tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		`CHK(nm, e, r)
	endtask

	task automatic st_chk(input int b, input logic e, input string nm);
		logic [31:0] r;
		apb(1'b0, itce_pkg::OFF_STAT, 32'h0, r);
		`CHK(nm, e, r[b])
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		st_chk(itce_pkg::STAT_IDLE, 1'b1, "idle at reset");
		wr(12'h100, 32'hFFFFFFFF);
		rd_chk(12'h100, 32'h0, "unmapped");
		wr(itce_pkg::OFF_VIC, 32'h5);
		rd_chk(itce_pkg::OFF_VIC, 32'h5, "view select");
	endtask

	task automatic ev_try(input logic [2:0] ts, input logic [31:0] rs,
		input logic [7:0] c, input logic [3:0] x, input logic e,
		input string nm);
		int n0;
		wr(itce_pkg::OFF_PRG, 32'h0);
		cyc(10);
		wr(itce_pkg::OFF_RSA, rs);
		wr(itce_pkg::OFF_EVC0, {29'h0, ts});
		wr(itce_pkg::OFF_PRG, 32'h1);
		cyc(4);
		n0 = sink.n_ev;
		cmp_in <= c;
		ext_in <= x;
		cyc(4);
		cmp_in <= 8'h00;
		ext_in <= 4'h0;
		cyc(10);
		`CHK(nm, e, sink.n_ev != n0)
	endtask

	task automatic t_select;
		wr(itce_pkg::OFF_EVC1, 32'h1);
		wr(itce_pkg::OFF_SSCI, 32'h20);
		ev_try(3'd0, 32'h0, 8'h00, 4'h0, 1'b0, "false");
		ev_try(3'd1, 32'h0, 8'h00, 4'h0, 1'b1, "true");
		ev_try(3'd2, 32'h2, 8'h00, 4'h2, 1'b1, "ext hit");
		ev_try(3'd2, 32'h2, 8'h00, 4'hD, 1'b0, "ext miss");
		ev_try(3'd2, 32'h10080, 8'h80, 4'h0, 1'b1, "cmp hit");
		ev_try(3'd2, 32'h10080, 8'h7F, 4'h0, 1'b0, "cmp miss");
		ev_try(3'd2, 32'h10005, 8'h04, 4'h0, 1'b1, "or");
		// Single-shot was set by the comparator cases; counter is still zero from reset
		wr(itce_pkg::OFF_RLD, 32'h2);
		wr(itce_pkg::OFF_SSCS, 32'h0);
		ev_try(3'd2, 32'h20001, 8'h00, 4'h0, 1'b0, "ctr run");
		ev_try(3'd2, 32'h20001, 8'h01, 4'h0, 1'b1, "ctr zero");
		ev_try(3'd2, 32'h30001, 8'h10, 4'h0, 1'b0, "ss miss");
		ev_try(3'd2, 32'h30001, 8'h20, 4'h0, 1'b1, "ss hit");
		ev_try(3'd2, 32'h400FF, 8'hFF, 4'hF, 1'b0, "reserved");
	endtask

	task automatic t_flush(input logic [2:0] vs, input int e);
		int s0;
		wr(itce_pkg::OFF_EVC0, 32'h0);
		wr(itce_pkg::OFF_CFG, 32'h10);
		wr(itce_pkg::OFF_VIC, {29'h0, vs});
		wr(itce_pkg::OFF_PRG, 32'h1);
		cyc(3);
		s0 = sink.inst_sum;
		retire <= 2'b11;
		cyc(1);
		retire <= 2'b00;
		start  <= 1'b1;
		cyc(1);
		start  <= 1'b0;
		cyc(1);
		for (int i = 0; i < 40 && flush_req === 1'b1; i++)
			cyc(1);
		`CHK("flush done", 1'b0, flush_req)
		`CHK("inst count", e, sink.inst_sum - s0)
		if (e != 0)
			`CHK("cyc count", 1'b1, sink.last_cyc != 12'h000)
	endtask

	task automatic t_lowpow;
		int s0;
		s0 = sink.inst_sum;
		retire    <= 2'b01;
		cyc(1);
		retire    <= 2'b00;
		cpu_sleep <= 1'b1;
		cyc(1);
		st_chk(itce_pkg::STAT_LP, 1'b0, "lp delay");
		cyc(10);
		st_chk(itce_pkg::STAT_LP, 1'b1, "lp entered");
		`CHK("lp drain", 1, sink.inst_sum - s0)
		cpu_sleep <= 1'b0;
		wr(itce_pkg::OFF_EVC1, 32'h1001);
		cpu_sleep <= 1'b1;
		cyc(12);
		st_chk(itce_pkg::STAT_LP, 1'b0, "lp override");
		cpu_sleep <= 1'b0;
		wr(itce_pkg::OFF_EVC1, 32'h1);
	endtask

	task automatic t_ovf;
		stall  <= 1'b1;
		retire <= 2'b11;
		cyc(12);
		retire <= 2'b00;
		stall  <= 1'b0;
		st_chk(itce_pkg::STAT_OVF, 1'b1, "overflow");
		wr(itce_pkg::OFF_PRG, 32'h1);
		st_chk(itce_pkg::STAT_OVF, 1'b0, "ovf clear");
	endtask

	task automatic t_idle;
		int n0;
		wr(itce_pkg::OFF_PRG, 32'h0);
		cyc(20);
		st_chk(itce_pkg::STAT_IDLE, 1'b1, "idle");
		n0 = sink.n_pkt;
		retire <= 2'b11;
		cyc(8);
		retire <= 2'b00;
		cyc(5);
		`CHK("quiet", n0, sink.n_pkt)
		`CHK("kinds", 0, sink.bad_kind)
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_select;
		t_flush(3'd0, 0);
		t_flush(3'd1, 2);
		t_lowpow;
		t_ovf;
		t_idle;
		give_verdict;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		give_verdict;
	end
endmodule

`default_nettype wire
